//--- rtl/bhpd_defines.svh
// constants of the host bus port decoder: offsets, status bits, flow codes
// assumes inclusion by the design module only
`ifndef BHPD_DEFINES_SVH
`define BHPD_DEFINES_SVH
`define BHPD_OFS_DATA 1'h0
`define BHPD_OFS_FLAGS 1'h1
`define BHPD_BIT_OUT_READY 1
`define BHPD_BIT_IN_BUSY 0
`define BHPD_CODE_NEAR_FULL 8'h11
`define BHPD_CODE_DRAINED 8'h13
`define BHPD_RX_DEPTH 1024
`define BHPD_RX_FREE_MARK 500
`define BHPD_RESET_RELEASE 8'h00
`endif

//--- rtl/bhpd_pkg.sv
// types of the host bus port decoder
// assumes nothing beyond the defines header
package bhpd_pkg;
  // one host bus cycle after pin synchronisation
  typedef struct packed {
    logic [7:0] addr; // host address a7..a0
    logic rd; // read strobe, active high
    logic wr; // write strobe, active high
    logic [7:0] wdata; // write data
  } bhpd_bus_s;
  // flow control state for the serial path
  typedef enum logic [0:0] {BHPD_FLOW_OPEN, BHPD_FLOW_PAUSED} bhpd_flow_e;
endpackage

//--- rtl/bhpd_port.sv
// host parallel port: decoder, data register, buffer flags, serial flow codes
// assumes host strobes and switches are asynchronous pins, one 125 MHz clock
`timescale 1ns/1ps
`include "bhpd_defines.svh"
// Operation
// R1: occupies two consecutive bytes at base
// R2: bus reset resets device when switch enables
// R3: a7..a1 compared against seven address switches
// R4: switches read inverted, on gives zero
// R5: fetch strobe gates decode only with jumper
// R6: offset zero is read/write data register
// R7: offset one is read-only status register
// R8: status bit1 set while outgoing byte waits
// R9: status bit0 clear when incoming buffer empty
// R10: status bits seven to two read zero
// R11: data register carries replies, keys, commands
// R12: serial mode makes bus registers unreachable
// R13: serial mode sends 11h near full
// R14: serial mode sends 13h once drained
// R15: sender pauses between near-full and drained codes
// R16: integrator avoids overlapping base addresses
// R17: a0 selects data or status register
// R18: host polls flags before data access
module bhpd_port import bhpd_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // host bus pins
  input wire logic [7:0] bus_addr,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_reset_n,
  input wire logic opcode_fetch_strobe_n,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_oe_n,
  // board straps
  input wire logic [7:0] config_switch_bank,
  input wire logic fetch_strobe_jumper,
  input wire logic serial_mode,
  // internal side: bytes from the host
  output logic [7:0] host_byte,
  output logic host_byte_valid,
  input wire logic host_byte_taken,
  // internal side: bytes toward the host
  input wire logic [7:0] reply_byte,
  input wire logic reply_load,
  output logic reply_pending,
  // internal side: serial receive buffer fill and flow codes
  input wire logic [10:0] rx_fill,
  output logic [7:0] flow_code,
  output logic flow_code_valid
);
  // two-stage synchronisers for every pin
  logic [7:0] s1_addr, s2_addr, s1_wd, s2_wd, s1_sw, s2_sw;
  logic [6:0] s1_ctl, s2_ctl;
  // previous strobe levels for edge detection
  logic rd_prev_ff, wr_prev_ff;
  // device-local reset from bus reset line
  logic soft_rst;
  bhpd_bus_s bus;
  logic hit, rd_edge, wr_edge, fetch_blocks;
  // buffers and flags
  logic [7:0] in_byte_ff, out_byte_ff;
  logic in_full_ff, out_full_ff;
  bhpd_flow_e flow_ff;
  logic near_full, drained;

  // synchronise all pins; first stage feeds only the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // strobes idle high and switches idle off, so no false edge follows reset
      s1_addr <= 8'h00;
      s2_addr <= 8'h00;
      s1_wd <= 8'h00;
      s2_wd <= 8'h00;
      s1_sw <= 8'hFF;
      s2_sw <= 8'hFF;
      s1_ctl <= 7'h0F;
      s2_ctl <= 7'h0F;
    end else begin
      s1_addr <= bus_addr;
      s2_addr <= s1_addr;
      s1_wd <= bus_wdata;
      s2_wd <= s1_wd;
      s1_sw <= config_switch_bank;
      s2_sw <= s1_sw;
      // bit 4 is a spare slot that keeps the strap bits at fixed places
      s1_ctl <= {serial_mode, fetch_strobe_jumper, 1'b0, bus_reset_n,
                 opcode_fetch_strobe_n, bus_wr_n, bus_rd_n};
      s2_ctl <= s1_ctl;
    end
  end

  // switch bit 0 low (on) connects bus reset; off switch reads one
  assign soft_rst = !s2_sw[0] && !s2_ctl[3]; // R2 R4

  // assemble the synchronised cycle
  always_comb begin
    bus.addr = s2_addr;
    bus.rd = !s2_ctl[0];
    bus.wr = !s2_ctl[1];
    bus.wdata = s2_wd;
  end

  // fetch cycles only block decode when the jumper is fitted
  assign fetch_blocks = s2_ctl[5] && !s2_ctl[2]; // R5
  // switches already give the address bits inverted-logic as printed
  assign hit = (bus.addr[7:1] == s2_sw[7:1]) && !fetch_blocks // R1 R3 R4
               && !s2_ctl[6]; // R12
  assign rd_edge = bus.rd && !rd_prev_ff;
  assign wr_edge = bus.wr && !wr_prev_ff;

  // strobe history
  // reset matches the idle strobe level, so no edge appears after reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
    end else begin
      rd_prev_ff <= bus.rd;
      wr_prev_ff <= bus.wr;
    end
  end

  // incoming buffer: host writes data offset, internal side drains
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_byte_ff <= 8'h00;
      in_full_ff <= 1'b0;
    end else if (soft_rst) begin
      in_byte_ff <= 8'h00;
      in_full_ff <= 1'b0;
    end else if (hit && wr_edge && bus.addr[0] == `BHPD_OFS_DATA) begin // R6 R17
      // a write onto a full buffer overwrites; host is expected to poll
      in_byte_ff <= bus.wdata; // R11
      in_full_ff <= 1'b1;
    end else if (host_byte_taken) begin
      // internal side has drained the byte
      in_full_ff <= 1'b0;
    end
  end

  // outgoing buffer: load wins over a host read in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_byte_ff <= 8'h00;
      out_full_ff <= 1'b0;
    end else if (soft_rst) begin
      out_byte_ff <= 8'h00;
      out_full_ff <= 1'b0;
    end else if (reply_load) begin
      out_byte_ff <= reply_byte; // R11
      out_full_ff <= 1'b1;
    end else if (hit && rd_edge && bus.addr[0] == `BHPD_OFS_DATA) begin // R6
      // host read of the data place empties it
      out_full_ff <= 1'b0;
    end
  end

  // read data and drive enable; enable low while driving
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= `BHPD_RESET_RELEASE;
      bus_rdata_oe_n <= 1'b1;
    end else begin
      bus_rdata_oe_n <= !(hit && bus.rd);
      if (bus.addr[0] == `BHPD_OFS_FLAGS) begin // R17
        // status word: clear, then drop the two flags into place
        bus_rdata <= 8'h00; // R7 R10
        bus_rdata[`BHPD_BIT_OUT_READY] <= out_full_ff; // R8
        bus_rdata[`BHPD_BIT_IN_BUSY] <= in_full_ff; // R9
      end else begin
        // data word: the byte waiting for the host
        bus_rdata <= out_byte_ff; // R6
      end
    end
  end

  // internal side outputs from flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      host_byte <= 8'h00;
      host_byte_valid <= 1'b0;
      reply_pending <= 1'b0;
    end else begin
      host_byte <= in_byte_ff;
      // valid drops on the edge that samples taken, so it is never counted twice
      host_byte_valid <= in_full_ff && !host_byte_taken;
      reply_pending <= out_full_ff;
    end
  end

  // serial flow codes; paused state prevents repeats
  // threshold leaves about five hundred bytes of room in the receive buffer
  assign near_full = rx_fill >= 11'(`BHPD_RX_DEPTH - `BHPD_RX_FREE_MARK);
  assign drained = rx_fill == 11'h000;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flow_ff <= BHPD_FLOW_OPEN;
      flow_code <= 8'h00;
      flow_code_valid <= 1'b0;
    end else if (soft_rst) begin // R2
      // a bus reset also forgets a pause, so no stale drained code follows
      flow_ff <= BHPD_FLOW_OPEN;
      flow_code_valid <= 1'b0;
    end else begin
      // valid is a one-cycle pulse unless a branch below raises it
      flow_code_valid <= 1'b0;
      case (flow_ff)
        BHPD_FLOW_OPEN: begin
          if (s2_ctl[6] && near_full) begin
            flow_ff <= BHPD_FLOW_PAUSED;
            flow_code <= `BHPD_CODE_NEAR_FULL; // R13
            flow_code_valid <= 1'b1;
          end
        end
        BHPD_FLOW_PAUSED: begin
          // drained code goes out only in serial mode
          if (drained) begin
            flow_ff <= BHPD_FLOW_OPEN;
            flow_code <= `BHPD_CODE_DRAINED; // R14
            flow_code_valid <= s2_ctl[6];
          end
        end
        default: flow_ff <= BHPD_FLOW_OPEN;
      endcase
    end
  end

  // checks: every property watches logic driven in this module
  // all run on the one clock and sleep while the async reset is held
  // the unused upper status bits read as zero
  chk_status_upper: assert property (@(posedge clock) disable iff (!arst_n) // R10
    (!bus_rdata_oe_n && $past(bus.addr[0]) && !$past(soft_rst)) |-> bus_rdata[7:2] == 6'h00)
    else $error("status upper bits not zero");

  // both flags land in their own bit positions of a status read
  chk_status_flags: assert property (@(posedge clock) disable iff (!arst_n) // R8 R9
    (!bus_rdata_oe_n && $past(bus.addr[0])) |->
      bus_rdata[1] == $past(out_full_ff) && bus_rdata[0] == $past(in_full_ff))
    else $error("status flags misplaced");

  // a data read returns the held outgoing byte, not the status word
  chk_data_select: assert property (@(posedge clock) disable iff (!arst_n) // R17
    (!bus_rdata_oe_n && !$past(bus.addr[0])) |-> bus_rdata == $past(out_byte_ff))
    else $error("data read shows wrong byte");

  // serial mode must leave the read drivers off
  chk_serial_block: assert property (@(posedge clock) disable iff (!arst_n) // R12
    s2_ctl[6] |=> bus_rdata_oe_n)
    else $error("bus driven in serial mode");

  // a data write captures the synchronised byte and raises the flag
  chk_write_sets: assert property (@(posedge clock) disable iff (!arst_n) // R6
    (hit && wr_edge && !bus.addr[0] && !soft_rst) |=>
      in_full_ff && in_byte_ff == $past(bus.wdata))
    else $error("write not captured");

  // a write aimed at the status place leaves the incoming byte unchanged
  chk_status_ro: assert property (@(posedge clock) disable iff (!arst_n) // R7
    (hit && wr_edge && bus.addr[0] && !soft_rst) |=> in_byte_ff == $past(in_byte_ff))
    else $error("status write landed");

  // a data read empties the outgoing place unless a new byte arrives
  chk_read_clears: assert property (@(posedge clock) disable iff (!arst_n) // R6
    (hit && rd_edge && !bus.addr[0] && !reply_load && !soft_rst) |=> !out_full_ff)
    else $error("outgoing flag not cleared");

  // a loaded reply raises the flag and then the pending output
  chk_ready_flag: assert property (@(posedge clock) disable iff (!arst_n) // R8
    (reply_load && !soft_rst) |=> out_full_ff ##1 reply_pending)
    else $error("outgoing flag not set");

  // a taken byte empties the incoming place and drops valid at once
  chk_taken_clears: assert property (@(posedge clock) disable iff (!arst_n) // R9
    (host_byte_taken && !wr_edge && !soft_rst) |=> !in_full_ff && !host_byte_valid)
    else $error("incoming flag not cleared");

  // an enabled bus reset empties both places
  chk_reset_clear: assert property (@(posedge clock) disable iff (!arst_n) // R2
    soft_rst |=> !in_full_ff && !out_full_ff)
    else $error("bus reset ignored");

  // a blocked fetch cycle never turns the read drivers on
  chk_fetch_gate: assert property (@(posedge clock) disable iff (!arst_n) // R5
    fetch_blocks |=> bus_rdata_oe_n)
    else $error("fetch cycle decoded");

  // the read drivers only come on after an address match
  chk_decode_match: assert property (@(posedge clock) disable iff (!arst_n) // R3
    !bus_rdata_oe_n |-> $past(bus.addr[7:1] == s2_sw[7:1]))
    else $error("decode mismatch");

  // crossing the fill mark sends the pause code once
  chk_xon_code: assert property (@(posedge clock) disable iff (!arst_n) // R13
    (flow_ff == BHPD_FLOW_OPEN && s2_ctl[6] && near_full && !soft_rst) |=>
      flow_code_valid && flow_code == 8'h11)
    else $error("near full code missing");

  // an emptied buffer sends the resume code once
  chk_xoff_code: assert property (@(posedge clock) disable iff (!arst_n) // R14
    (flow_ff == BHPD_FLOW_PAUSED && drained && s2_ctl[6] && !soft_rst) |=>
      flow_code_valid && flow_code == 8'h13)
    else $error("drained code missing");

  // no flow code leaves the block outside serial mode
  chk_code_serial: assert property (@(posedge clock) disable iff (!arst_n) // R13 R14
    flow_code_valid |-> $past(s2_ctl[6]))
    else $error("flow code outside serial mode");
endmodule

//--- tb/bhpd_host_model.sv
// control card model: drives address, strobes and write data
// assumes calls from one bench process, one 125 MHz clock
`timescale 1ns/1ps
module bhpd_host_model (
  // clock and read answer
  input wire logic clock,
  input wire logic [7:0] rdata,
  input wire logic oe_n,
  // bus pins toward the port
  output logic [7:0] addr,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] wdata
);
  // idle bus: strobes high
  initial begin
    addr = 8'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
    wdata = 8'hA5;
  end
  // one transfer: strobe low five edges, then high four edges
  task automatic cyc(input logic [7:0] a, input logic wr, input logic [7:0] d,
                     output logic [8:0] q);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    if (wr) begin
      wr_n <= 1'b0;
    end else begin
      rd_n <= 1'b0;
    end
    repeat (4) @(posedge clock);
    #1;
    q = {oe_n, rdata};
    @(posedge clock);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // released data lines must not look like the last byte
    wdata <= ~d;
    repeat (4) @(posedge clock);
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench: decode table, registers, bus reset, flow codes
// assumes the host model drives the bus pins, one 125 MHz clock
`timescale 1ns/1ps
module tb_top;
  logic clock;
  logic arst_n, bus_reset_n, fetch_n, jumper, serial_mode, taken, load;
  logic rd_n, wr_n, oe_n, hb_valid, pending, fc_valid;
  logic [7:0] addr, wdata, sw, reply, rdata, host_byte, flow_code;
  logic [10:0] rx_fill;
  logic [8:0] q;
  int failures = 0;
  int total_checks = 0;
  // rows: switches, jumper, fetch strobe, serial, address, hit
  localparam logic [19:0] ROWS [8] = '{
    {8'hC0, 3'b110, 8'hC1, 1'b1}, {8'hC0, 3'b110, 8'hC3, 1'b0},
    {8'hC0, 3'b110, 8'h41, 1'b0}, {8'h41, 3'b000, 8'h41, 1'b1},
    {8'h41, 3'b100, 8'h41, 1'b0}, {8'hFE, 3'b010, 8'hFF, 1'b1},
    {8'h00, 3'b010, 8'h01, 1'b1}, {8'hC0, 3'b111, 8'hC1, 1'b0}};
  bhpd_port i_bhpd_port (.clock(clock), .arst_n(arst_n), .bus_addr(addr),
    .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_wdata(wdata), .bus_reset_n(bus_reset_n),
    .opcode_fetch_strobe_n(fetch_n), .bus_rdata(rdata), .bus_rdata_oe_n(oe_n),
    .config_switch_bank(sw), .fetch_strobe_jumper(jumper), .serial_mode(serial_mode),
    .host_byte(host_byte), .host_byte_valid(hb_valid), .host_byte_taken(taken),
    .reply_byte(reply), .reply_load(load), .reply_pending(pending),
    .rx_fill(rx_fill), .flow_code(flow_code), .flow_code_valid(fc_valid));
  bhpd_host_model i_bhpd_host_model (.clock(clock), .rdata(rdata), .oe_n(oe_n),
    .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata));
  // compare and count
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // the flow code must pulse within eight cycles
  task automatic wait_code(input logic [7:0] exp);
    logic [8:0] got;
    got = 9'h000;
    repeat (8) begin
      @(posedge clock);
      #1;
      if (fc_valid === 1'b1) got = {1'b1, flow_code};
    end
    chk(got, {1'b1, exp});
  endtask
  // write a byte, pulse bus reset, see whether it survived
  task automatic brst(input logic [7:0] s, input logic [8:0] exp);
    sw <= s;
    i_bhpd_host_model.cyc(8'hC0, 1'b1, 8'hA1, q);
    bus_reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    bus_reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk({hb_valid, 8'h00}, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // watchdog well beyond the expected run
  initial begin
    #40000;
    failures++;
    end_sim();
  end
  initial begin
    {arst_n, bus_reset_n, fetch_n, jumper, serial_mode, taken, load} = 7'b0110000;
    sw = 8'hC0;
    reply = 8'h00;
    rx_fill = 11'd0;
    repeat (2) @(posedge clock);
    #1;
    chk({oe_n, hb_valid, pending, fc_valid, 5'h00}, 9'h100);
    // release on the third edge, by non-blocking assignment
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (ROWS[i]) begin
      {sw, jumper, fetch_n, serial_mode} <= ROWS[i][19:9];
      repeat (3) @(posedge clock);
      i_bhpd_host_model.cyc(ROWS[i][8:1], 1'b0, 8'h00, q);
      chk({q[8], ROWS[i][0] ? q[7:0] : 8'h00}, {~ROWS[i][0], 8'h00});
    end
    {sw, jumper, fetch_n, serial_mode} <= 11'h602;
    repeat (3) @(posedge clock);
    i_bhpd_host_model.cyc(8'hC0, 1'b1, 8'h5A, q);
    chk({hb_valid, host_byte}, 9'h15A);
    i_bhpd_host_model.cyc(8'hC1, 1'b0, 8'h00, q);
    chk(q, 9'h001);
    taken <= 1'b1;
    @(posedge clock);
    taken <= 1'b0;
    i_bhpd_host_model.cyc(8'hC1, 1'b0, 8'h00, q);
    chk(q, 9'h000);
    // status place is read-only
    i_bhpd_host_model.cyc(8'hC1, 1'b1, 8'h77, q);
    chk({hb_valid, 8'h00}, 9'h000);
    reply <= 8'h3C;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    i_bhpd_host_model.cyc(8'hC1, 1'b0, 8'h00, q);
    chk(q, 9'h002);
    chk({pending, 8'h00}, 9'h100);
    i_bhpd_host_model.cyc(8'hC0, 1'b0, 8'h00, q);
    chk(q, 9'h03C);
    chk({pending, 8'h00}, 9'h000);
    i_bhpd_host_model.cyc(8'hC1, 1'b0, 8'h00, q);
    chk(q, 9'h000);
    // fetch cycle with the jumper fitted: write refused, old byte stays
    {jumper, fetch_n} <= 2'b10;
    repeat (3) @(posedge clock);
    i_bhpd_host_model.cyc(8'hC0, 1'b1, 8'h99, q);
    chk({hb_valid, host_byte}, 9'h05A);
    {jumper, fetch_n} <= 2'b01;
    repeat (3) @(posedge clock);
    brst(8'hC0, 9'h000);
    brst(8'hC1, 9'h100);
    // mid-run async reset while a byte is still held
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({oe_n, hb_valid, pending, fc_valid, 5'h00}, 9'h100);
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    serial_mode <= 1'b1;
    rx_fill <= 11'd524;
    wait_code(8'h11);
    @(posedge clock);
    rx_fill <= 11'd0;
    wait_code(8'h13);
    end_sim();
  end
endmodule
